// ---- design/sync_osc_offset_iq_pkg.sv ----
package sync_osc_offset_iq_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_SYNC_SOURCE_CONTROL = 5'h05;
    localparam logic [4:0] ADDR_FIXED_SAMPLE_LOW    = 5'h06;
    localparam logic [4:0] ADDR_FIXED_SAMPLE_HIGH   = 5'h07;
    localparam logic [4:0] ADDR_DATAPATH_BYPASS     = 5'h08;
    localparam logic [4:0] ADDR_OSC_FREQ_BYTE0      = 5'h09;
    localparam logic [4:0] ADDR_OSC_FREQ_BYTE1      = 5'h0a;
    localparam logic [4:0] ADDR_OSC_FREQ_BYTE3      = 5'h0b;
    localparam logic [4:0] ADDR_OSC_FREQ_BYTE2      = 5'h0c;
    localparam logic [4:0] ADDR_OSC_PHASE_BYTE0     = 5'h0d;
    localparam logic [4:0] ADDR_OSC_PHASE_BYTE1     = 5'h0e;
    localparam logic [4:0] ADDR_CHAN_A_OFFSET_LOW   = 5'h0f;
    localparam logic [4:0] ADDR_CHAN_B_OFFSET_LOW   = 5'h10;
    localparam logic [4:0] ADDR_CHAN_A_OFFSET_HIGH  = 5'h11;
    localparam logic [4:0] ADDR_CHAN_B_OFFSET_HIGH  = 5'h12;
    localparam logic [4:0] ADDR_IQ_GAIN_A_LOW       = 5'h13;
    localparam logic [4:0] ADDR_IQ_GAIN_B_LOW       = 5'h14;
    localparam logic [4:0] ADDR_IQ_PHASE_LOW        = 5'h15;
    localparam logic [4:0] ADDR_IQ_PHASE_GAIN_HIGH  = 5'h16;
    localparam logic [4:0] ADDR_FIRST               = ADDR_SYNC_SOURCE_CONTROL;
    localparam logic [4:0] ADDR_LAST                = ADDR_IQ_PHASE_GAIN_HIGH;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_DEFAULT       = 8'h00;
    localparam logic [7:0] RESET_OSC_FREQ_BYTE2 = 8'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DIVIDER_RESTART   = 7;
    localparam int BIT_OSC_CLEAR         = 6;
    localparam int BIT_COARSE_MIX_RESTART = 5;
    localparam int SYNC_SEL_MSB          = 4;
    localparam int SYNC_SEL_LSB          = 2;
    localparam logic [7:0] MASK_CHAN_A_OFFSET_HIGH = 8'hfc;
    localparam logic [7:0] MASK_CHAN_B_OFFSET_HIGH = 8'hf8;

    // ------------------------------------------------------------
    // Buffer sync source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SYNC_TX_ENABLE    = 3'h0;
    localparam logic [2:0] SYNC_PHASE_STROBE = 3'h1;
    localparam logic [2:0] SYNC_B_SAMPLE     = 3'h2;
    localparam logic [2:0] SYNC_PORT_B_MSB   = 3'h3;
    localparam logic [2:0] SYNC_PORT_A_ONCE  = 3'h4;
    localparam logic [2:0] SYNC_SOFTWARE     = 3'h5;
    localparam logic [2:0] SYNC_OFF          = 3'h6;
    localparam logic [2:0] SYNC_ON           = 3'h7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] data;
    } reg_req_t;

    typedef struct packed {
        logic divider_restart;
        logic osc_clear;
        logic coarse_mix_restart;
        logic buffer_init;
    } sync_pulse_t;

endpackage

// ---- design/sync_osc_offset_iq_regs.sv ----
`timescale 1ns/1ns
// Contract
// RQ1: Divider restart bit set: phase strobe rising edge restarts clock dividers.
// RQ2: Oscillator clear bit set: phase strobe rising edge clears phase accumulator.
// RQ3: Coarse mix restart bit set: phase strobe rising edge restarts mixer sequence.
// RQ4: Rising edge of chosen buffer sync source initialises both buffer pointers.
// RQ5: Select 000 transmit enable, 001 strobe, 010 B flag, 011 port B msb.
// RQ6: Select 100 syncs once on first port A msb rising edge only.
// RQ7: Select 101 syncs from a software register write.
// RQ8: Select 110 holds source inactive, 111 holds it active.
// RQ9: Fixed sample low byte from 0x06, high byte from 0x07.
// RQ10: Software leaves bypass mask at 0x08 at its reset value.
// RQ11: Frequency word bytes from 0x09, 0x0A, 0x0C, 0x0B, low to high.
// RQ12: Phase offset word low byte 0x0D, high byte 0x0E.
// RQ13: Channel A offset: 7:0 from 0x0F, 12:8 in top five bits of 0x11.
// RQ14: Channel B offset: 7:0 from 0x10, 12:8 in top five bits of 0x12.
// RQ15: Offset B, offset A high, IQ words shadowed until 0x0F written.
// RQ16: IQ gain A low byte from 0x13, IQ gain B low byte from 0x14.
// RQ17: IQ phase low byte from 0x15.
// RQ18: 0x16 holds IQ phase 9:8, gain A 10:8, gain B 10:8, top down.
// RQ19: Fixed sample select replaces both converter inputs with the fixed sample.
// RQ20: Sync edges found by sampling source and comparing with previous sample.
module sync_osc_offset_iq_regs (
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire sync_osc_offset_iq_pkg::reg_req_t    req,
    output logic [7:0]                               rd_data,
    output logic                                     rd_valid,
    input  wire logic                                tx_enable,
    input  wire logic                                phase_strobe,
    input  wire logic                                b_sample_flag,
    input  wire logic [15:0]                         port_a_data,
    input  wire logic [15:0]                         port_b_data,
    input  wire logic                                fixed_sample_sel,
    output logic [15:0]                              conv_a_data,
    output logic [15:0]                              conv_b_data,
    output sync_osc_offset_iq_pkg::sync_pulse_t      sync_pulse,
    output logic [7:0]                               bypass_mask,
    output logic [31:0]                              osc_freq,
    output logic [15:0]                              osc_phase,
    output logic [12:0]                              chan_a_offset,
    output logic [12:0]                              chan_b_offset,
    output logic [10:0]                              iq_gain_a,
    output logic [10:0]                              iq_gain_b,
    output logic [9:0]                               iq_phase
);
    import sync_osc_offset_iq_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Address belongs to this bank
    function automatic logic is_mapped(input logic [4:0] addr);
        is_mapped = (addr >= ADDR_FIRST) && (addr <= ADDR_LAST);
    endfunction

    // Bits that hold storage at each address
    function automatic logic [7:0] field_mask(input logic [4:0] addr);
        if (addr == ADDR_CHAN_A_OFFSET_HIGH) begin
            field_mask = MASK_CHAN_A_OFFSET_HIGH;
        end else if (addr == ADDR_CHAN_B_OFFSET_HIGH) begin
            field_mask = MASK_CHAN_B_OFFSET_HIGH;
        end else begin
            field_mask = 8'hff;
        end
    endfunction

    // Value after reset at each address
    function automatic logic [7:0] reset_value(input logic [4:0] addr);
        if (addr == ADDR_OSC_FREQ_BYTE2) begin
            reset_value = RESET_OSC_FREQ_BYTE2;
        end else begin
            reset_value = RESET_DEFAULT;
        end
    endfunction

    // ------------------------------------------------------------
    // Register storage (software view, shadows included)
    // ------------------------------------------------------------
    logic [7:0]  regs_reg [0:31];
    logic        wr_hit;
    logic        commit;

    assign wr_hit = req.wr && is_mapped(req.addr);
    assign commit = req.wr && (req.addr == ADDR_CHAN_A_OFFSET_LOW);   // see RQ15

    // One byte per address; bits outside field_mask kept at zero
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_byte
            localparam logic [4:0] A = 5'(gi);
            if ((gi >= int'(ADDR_FIRST)) && (gi <= int'(ADDR_LAST))) begin : g_live
                always_ff @(posedge clk) begin
                    if (!rst_b) begin
                        regs_reg[gi] <= reset_value(A);
                    end else if (wr_hit && (req.addr == A)) begin
                        regs_reg[gi] <= req.data & field_mask(A);   // see RQ13
                    end
                end
            end else begin : g_none
                always_ff @(posedge clk) begin
                    regs_reg[gi] <= 8'h00;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Read answer one cycle after request; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= is_mapped(req.addr) ? regs_reg[req.addr] : 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Direct-acting words
    // ------------------------------------------------------------
    logic [15:0] fixed_sample;

    assign fixed_sample = {regs_reg[ADDR_FIXED_SAMPLE_HIGH],
                           regs_reg[ADDR_FIXED_SAMPLE_LOW]};                // see RQ9
    assign bypass_mask  = regs_reg[ADDR_DATAPATH_BYPASS];                   // see RQ10
    assign osc_freq     = {regs_reg[ADDR_OSC_FREQ_BYTE3],
                           regs_reg[ADDR_OSC_FREQ_BYTE2],
                           regs_reg[ADDR_OSC_FREQ_BYTE1],
                           regs_reg[ADDR_OSC_FREQ_BYTE0]};                  // see RQ11
    assign osc_phase    = {regs_reg[ADDR_OSC_PHASE_BYTE1],
                           regs_reg[ADDR_OSC_PHASE_BYTE0]};                 // see RQ12

    // ------------------------------------------------------------
    // Shadowed words, loaded on channel A offset low write
    // ------------------------------------------------------------
    logic [7:0] a_high;
    logic [7:0] b_high;
    logic [7:0] iq_high;

    assign a_high  = regs_reg[ADDR_CHAN_A_OFFSET_HIGH];
    assign b_high  = regs_reg[ADDR_CHAN_B_OFFSET_HIGH];
    assign iq_high = regs_reg[ADDR_IQ_PHASE_GAIN_HIGH];

    // Active copies used by the datapath
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chan_a_offset <= 13'h0000;
            chan_b_offset <= 13'h0000;
            iq_gain_a     <= 11'h000;
            iq_gain_b     <= 11'h000;
            iq_phase      <= 10'h000;
        end else if (commit) begin                                          // see RQ15
            chan_a_offset <= {a_high[7:3], req.data};                       // see RQ13
            chan_b_offset <= {b_high[7:3], regs_reg[ADDR_CHAN_B_OFFSET_LOW]}; // see RQ14
            iq_gain_a     <= {iq_high[5:3], regs_reg[ADDR_IQ_GAIN_A_LOW]};  // see RQ16
            iq_gain_b     <= {iq_high[2:0], regs_reg[ADDR_IQ_GAIN_B_LOW]};  // see RQ18
            iq_phase      <= {iq_high[7:6], regs_reg[ADDR_IQ_PHASE_LOW]};   // see RQ17
        end
    end

    // ------------------------------------------------------------
    // Converter input selection
    // ------------------------------------------------------------

    // Fixed sample replaces both paths when selected
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_a_data <= 16'h0000;
            conv_b_data <= 16'h0000;
        end else begin
            conv_a_data <= fixed_sample_sel ? fixed_sample : port_a_data;   // see RQ19
            conv_b_data <= fixed_sample_sel ? fixed_sample : port_b_data;   // see RQ19
        end
    end

    // ------------------------------------------------------------
    // Phase strobe edge and restarts
    // ------------------------------------------------------------
    logic [7:0] ctl;
    logic [2:0] sync_sel;
    logic       strobe_now_reg;
    logic       strobe_prev_reg;
    logic       strobe_rise;

    assign ctl         = regs_reg[ADDR_SYNC_SOURCE_CONTROL];
    assign sync_sel    = ctl[SYNC_SEL_MSB:SYNC_SEL_LSB];
    assign strobe_rise = strobe_now_reg && !strobe_prev_reg;                // see RQ20

    // Strobe sample and previous sample
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobe_now_reg  <= 1'b0;
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_now_reg  <= phase_strobe;
            strobe_prev_reg <= strobe_now_reg;
        end
    end

    // Restart pulses gated by their enable bits
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_pulse.divider_restart    <= 1'b0;
            sync_pulse.osc_clear          <= 1'b0;
            sync_pulse.coarse_mix_restart <= 1'b0;
        end else begin
            sync_pulse.divider_restart    <= strobe_rise && ctl[BIT_DIVIDER_RESTART];    // see RQ1
            sync_pulse.osc_clear          <= strobe_rise && ctl[BIT_OSC_CLEAR];          // see RQ2
            sync_pulse.coarse_mix_restart <= strobe_rise && ctl[BIT_COARSE_MIX_RESTART]; // see RQ3
        end
    end

    // ------------------------------------------------------------
    // Buffer sync source
    // ------------------------------------------------------------
    logic port_a_msb;
    logic port_b_msb;
    logic sw_sync_reg;
    logic once_done_reg;
    logic src_level;
    logic src_now_reg;
    logic src_prev_reg;
    logic src_rise;

    assign port_a_msb = port_a_data[15];
    assign port_b_msb = port_b_data[15];
    assign src_rise   = src_now_reg && !src_prev_reg;                       // see RQ20

    // Software sync: write of the control byte carrying code 101
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sw_sync_reg <= 1'b0;
        end else begin
            sw_sync_reg <= req.wr && (req.addr == ADDR_SYNC_SOURCE_CONTROL)
                           && (req.data[SYNC_SEL_MSB:SYNC_SEL_LSB] == SYNC_SOFTWARE); // see RQ7
        end
    end

    // One-shot latch; rearmed by a control write, the catch wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            once_done_reg <= 1'b0;
        end else if (src_rise && (sync_sel == SYNC_PORT_A_ONCE)) begin
            once_done_reg <= 1'b1;                                          // see RQ6
        end else if (req.wr && (req.addr == ADDR_SYNC_SOURCE_CONTROL)) begin
            once_done_reg <= 1'b0;
        end
    end

    // Source selection
    always_comb begin
        unique case (sync_sel)
            SYNC_TX_ENABLE:    src_level = tx_enable;                       // see RQ5
            SYNC_PHASE_STROBE: src_level = phase_strobe;                    // see RQ5
            SYNC_B_SAMPLE:     src_level = b_sample_flag;                   // see RQ5
            SYNC_PORT_B_MSB:   src_level = port_b_msb;                      // see RQ5
            SYNC_PORT_A_ONCE:  src_level = port_a_msb && !once_done_reg;    // see RQ6
            SYNC_SOFTWARE:     src_level = sw_sync_reg;                     // see RQ7
            SYNC_OFF:          src_level = 1'b0;                            // see RQ8
            SYNC_ON:           src_level = 1'b1;                            // see RQ8
        endcase
    end

    // Source sample, previous sample and pointer init pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            src_now_reg            <= 1'b0;
            src_prev_reg           <= 1'b0;
            sync_pulse.buffer_init <= 1'b0;
        end else begin
            src_now_reg            <= src_level;
            src_prev_reg           <= src_now_reg;
            sync_pulse.buffer_init <= src_rise;                             // see RQ4
        end
    end

endmodule

// ---- verification/sync_osc_offset_iq_regs_checker.sv ----
`timescale 1ns/1ns
module regs_checker (
    input wire logic                                clk,
    input wire logic                                rst_b,
    input wire sync_osc_offset_iq_pkg::reg_req_t    req,
    input wire logic [7:0]                          rd_data,
    input wire logic                                rd_valid,
    input wire logic                                tx_enable,
    input wire logic                                phase_strobe,
    input wire logic                                b_sample_flag,
    input wire logic [15:0]                         port_a_data,
    input wire logic [15:0]                         port_b_data,
    input wire logic                                fixed_sample_sel,
    input wire logic [15:0]                         conv_a_data,
    input wire logic [15:0]                         conv_b_data,
    input wire sync_osc_offset_iq_pkg::sync_pulse_t sync_pulse,
    input wire logic [7:0]                          bypass_mask,
    input wire logic [31:0]                         osc_freq,
    input wire logic [15:0]                         osc_phase,
    input wire logic [12:0]                         chan_a_offset,
    input wire logic [12:0]                         chan_b_offset,
    input wire logic [10:0]                         iq_gain_a,
    input wire logic [10:0]                         iq_gain_b,
    input wire logic [9:0]                          iq_phase
);
    import sync_osc_offset_iq_pkg::*;
    logic [7:0]  mem_reg [0:31];
    logic [7:0]  ctl;
    logic [15:0] fixed_w;
    logic        wr5;
    logic        commit;
    logic        src;
    // Decoded views of the mirror and of the request
    assign ctl = mem_reg[5];
    assign fixed_w = {mem_reg[7], mem_reg[6]};
    assign wr5 = req.wr && req.addr == ADDR_SYNC_SOURCE_CONTROL;
    assign commit = req.wr && req.addr == ADDR_CHAN_A_OFFSET_LOW;
    assign src = (ctl[3:2] == 2'h0) ? tx_enable : (ctl[3:2] == 2'h1) ? phase_strobe :
                 (ctl[3:2] == 2'h2) ? b_sample_flag : port_b_data[15];
    // Mirror of every byte written, shadows included
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 32; i++) begin
                mem_reg[i] <= (i == 12) ? RESET_OSC_FREQ_BYTE2 : RESET_DEFAULT;
            end
        end else if (req.wr) begin
            mem_reg[req.addr] <= req.data;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_divider_restart:
        assert property ($rose(phase_strobe) && ctl[BIT_DIVIDER_RESTART] && !wr5
            |-> ##2 sync_pulse.divider_restart) else $error("divider restart pulse missing");
    chk_osc_clear:
        assert property ($rose(phase_strobe) && ctl[BIT_OSC_CLEAR] && !wr5
            |-> ##2 sync_pulse.osc_clear) else $error("oscillator clear pulse missing");
    chk_coarse_restart:
        assert property ($rose(phase_strobe) && ctl[BIT_COARSE_MIX_RESTART] && !wr5
            |-> ##2 sync_pulse.coarse_mix_restart) else $error("coarse mix pulse missing");
    chk_source_edge:
        assert property (!ctl[4] && $stable(ctl) && !wr5 && $rose(src)
            |-> ##2 sync_pulse.buffer_init) else $error("buffer init pulse missing");
    chk_software_sync:
        assert property (wr5 && req.data[4:2] == SYNC_SOFTWARE
            |-> ##[2:3] sync_pulse.buffer_init) else $error("software sync pulse missing");
    chk_level_source:
        assert property (ctl[4:3] == 2'h3 && $past(ctl) == ctl && $past(ctl, 2) == ctl
            && $past(ctl, 3) == ctl |-> !sync_pulse.buffer_init) else $error("fixed source pulsed");
    chk_fixed_sample:
        assert property (fixed_sample_sel |=> conv_a_data == $past(fixed_w)
            && conv_b_data == $past(fixed_w)) else $error("fixed sample not on converters");
    chk_direct_data:
        assert property (!fixed_sample_sel |=> conv_a_data == $past(port_a_data)
            && conv_b_data == $past(port_b_data)) else $error("converter data not passed");
    chk_osc_words:
        assert property (osc_freq == {mem_reg[11], mem_reg[12], mem_reg[10], mem_reg[9]}
            && osc_phase == {mem_reg[14], mem_reg[13]}) else $error("oscillator word wrong");
    chk_offset_commit:
        assert property (commit |=> chan_a_offset == {mem_reg[17][7:3], mem_reg[15]}
            && chan_b_offset == {mem_reg[18][7:3], mem_reg[16]}
            && iq_gain_a == {mem_reg[22][5:3], mem_reg[19]}
            && iq_gain_b == {mem_reg[22][2:0], mem_reg[20]}
            && iq_phase == {mem_reg[22][7:6], mem_reg[21]}) else $error("commit words wrong");
    chk_shadow_hold:
        assert property (!commit |=> $stable(chan_a_offset) && $stable(chan_b_offset)
            && $stable(iq_gain_a) && $stable(iq_gain_b) && $stable(iq_phase))
            else $error("shadow leaked early");
endmodule
bind sync_osc_offset_iq_regs regs_checker u_regs_checker (.clk(clk), .rst_b(rst_b), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .tx_enable(tx_enable), .phase_strobe(phase_strobe),
    .b_sample_flag(b_sample_flag), .port_a_data(port_a_data), .port_b_data(port_b_data),
    .fixed_sample_sel(fixed_sample_sel), .conv_a_data(conv_a_data), .conv_b_data(conv_b_data),
    .sync_pulse(sync_pulse), .bypass_mask(bypass_mask), .osc_freq(osc_freq),
    .osc_phase(osc_phase), .chan_a_offset(chan_a_offset), .chan_b_offset(chan_b_offset),
    .iq_gain_a(iq_gain_a), .iq_gain_b(iq_gain_b), .iq_phase(iq_phase));

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import sync_osc_offset_iq_pkg::*;
    typedef struct packed {logic [4:0] a; logic [7:0] w; logic [7:0] r;} row_t;
    logic        clk, rst_b, tx_enable, phase_strobe, b_sample_flag, fixed_sample_sel, rd_valid;
    logic [7:0]  rd_data, bypass_mask;
    logic [15:0] port_a_data, port_b_data, conv_a_data, conv_b_data, osc_phase;
    logic [31:0] osc_freq;
    logic [12:0] chan_a_offset, chan_b_offset;
    logic [10:0] iq_gain_a, iq_gain_b;
    logic [9:0]  iq_phase;
    reg_req_t    req;
    sync_pulse_t sync_pulse;
    int          bad_count, cmp_count, n_pulse [4];
    row_t        rows [16] = '{'{5'h06, 8'ha5, 8'ha5}, '{5'h07, 8'h3c, 8'h3c},
        '{5'h09, 8'h11, 8'h11}, '{5'h0a, 8'h22, 8'h22}, '{5'h0b, 8'h44, 8'h44},
        '{5'h0c, 8'h33, 8'h33}, '{5'h0d, 8'h55, 8'h55}, '{5'h0e, 8'h66, 8'h66},
        '{5'h10, 8'h77, 8'h77}, '{5'h11, 8'hff, 8'hfc}, '{5'h12, 8'hff, 8'hf8},
        '{5'h13, 8'h81, 8'h81}, '{5'h14, 8'h92, 8'h92}, '{5'h15, 8'ha3, 8'ha3},
        '{5'h16, 8'hb6, 8'hb6}, '{5'h18, 8'h5a, 8'h00}};
    sync_osc_offset_iq_regs u_sync_osc_offset_iq_regs (.clk(clk), .rst_b(rst_b), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .tx_enable(tx_enable),
        .phase_strobe(phase_strobe), .b_sample_flag(b_sample_flag), .port_a_data(port_a_data),
        .port_b_data(port_b_data), .fixed_sample_sel(fixed_sample_sel),
        .conv_a_data(conv_a_data), .conv_b_data(conv_b_data), .sync_pulse(sync_pulse),
        .bypass_mask(bypass_mask), .osc_freq(osc_freq), .osc_phase(osc_phase),
        .chan_a_offset(chan_a_offset), .chan_b_offset(chan_b_offset), .iq_gain_a(iq_gain_a),
        .iq_gain_b(iq_gain_b), .iq_phase(iq_phase));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic reg_rd(input logic [4:0] a, input logic [7:0] e);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge clk);
        req = '0;
        chk("read", {1'b1, e}, {rd_valid, rd_data});
    endtask
    // Count pulses per sync output over n cycles
    task automatic watch(input int n);
        n_pulse = '{0, 0, 0, 0};
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) n_pulse[i] += sync_pulse[i];
        end
    endtask
    task automatic set_src(input int code, input logic v);
        case (code)
            0: tx_enable = v;
            1: phase_strobe = v;
            2: b_sample_flag = v;
            3: port_b_data[15] = v;
            default: port_a_data[15] = v;
        endcase
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
    initial begin
        {rst_b, tx_enable, phase_strobe, b_sample_flag, fixed_sample_sel} = '0;
        {port_a_data, port_b_data} = '0;
        req = '0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        for (int a = 5; a < 23; a++) reg_rd(5'(a), (a == 12) ? 8'h40 : 8'h00);
        chk("bypass", 32'h0, bypass_mask);
        foreach (rows[i]) begin
            reg_wr(rows[i].a, rows[i].w);
            reg_rd(rows[i].a, rows[i].r);
        end
        chk("freq", 32'h44332211, osc_freq);
        chk("phase", 32'h6655, osc_phase);
        chk("shadow offsets", 32'h0, {chan_a_offset, chan_b_offset});
        chk("shadow iq", 32'h0, {iq_gain_a, iq_gain_b, iq_phase});
        reg_wr(5'h0f, 8'hc8);
        chk("offsets", {13'h1fc8, 13'h1f77}, {chan_a_offset, chan_b_offset});
        chk("iq", {11'h681, 11'h692, 10'h2a3}, {iq_gain_a, iq_gain_b, iq_phase});
        fixed_sample_sel = 1'b1;
        repeat (2) @(negedge clk);
        chk("fixed", 32'h3ca53ca5, {conv_a_data, conv_b_data});
        {fixed_sample_sel, port_a_data, port_b_data} = {1'b0, 16'h1234, 16'h0567};
        repeat (2) @(negedge clk);
        chk("direct", 32'h12340567, {conv_a_data, conv_b_data});
        for (int k = 0; k < 2; k++) begin
            reg_wr(5'h05, k == 0 ? 8'he0 : 8'h00);
            set_src(1, 1'b1);
            watch(6);
            chk("strobe", k == 0 ? 32'h111 : 32'h0,
                {n_pulse[3][3:0], n_pulse[2][3:0], n_pulse[1][3:0]});
            set_src(1, 1'b0);
        end
        for (int c = 0; c < 5; c++) begin
            reg_wr(5'h05, 8'(c * 4));
            for (int k = 0; k < 2; k++) begin
                set_src(c, 1'b1);
                watch(6);
                chk("buffer sync", (c == 4 && k == 1) ? 0 : 1, n_pulse[0]);
                set_src(c, 1'b0);
                @(negedge clk);
            end
        end
        reg_wr(5'h05, 8'h14);
        watch(6);
        chk("software sync", 32'h1, n_pulse[0]);
        reg_wr(5'h05, 8'h18);
        for (int c = 0; c < 5; c++) set_src(c, 1'b1);
        watch(6);
        chk("sync off", 32'h0, n_pulse[0]);
        for (int c = 0; c < 5; c++) set_src(c, 1'b0);
        reg_wr(5'h05, 8'h1c);
        watch(8);
        chk("sync on", 32'h1, n_pulse[0]);
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        chk("reset freq", 32'h00400000, osc_freq);
        chk("reset offset", 32'h0, chan_a_offset);
        reg_rd(5'h0c, 8'h40);
        print_verdict();
    end
endmodule
